// file: hbd_core.sv
// serial slave, control word, supply and thermal supervision of six half-bridges
`timescale 1ns/1ps
`default_nettype none
`include "hbd_params.svh"

// Summary of operation
// - reset clears all stored data and places every bridge output off.
// - inhibit low means sleep: outputs off, serial registers held in reset.
// - supply undervoltage turns outputs off, keeps logic, shows supply fail until recovery.
// - supply overvoltage turns outputs off, unlatched supply fail, auto restart after.
// - logic supply undervoltage stops serial link and initialises all logic.
// - thermal warning bit follows the warning sensor level.
// - thermal shutdown latches all outputs off until status clear or reset.
// - qualified overcurrent turns the switch off and latches its flag.
// - qualified low-side open load latches its flag, switch stays on.
// - with shutdown enabled, open load also latches the output off.
// - never both switches of a bridge on; dead time between them.
// - cross-current turns both switches off and sets overcurrent flag.
// - each frame carries a 16-bit control word in and status out.
// - sample on falling serial clock edge, most significant bit first.
// - chip select low frames the transfer; its rise takes the control word.
// - data output released when chip select returns high.
// - control word applies at frame end and holds until replaced or reset.
// - diagnostic data captured into the shifter at chip select fall.
// - shifted-in bits pass on through the data output for daisy chains.
// - frame length is checked in clock counts before acting.
// - status clear bit clears latched errors of the addressed register.
// - address of one frame selects the status returned in the next.
// - activate bit enables a bridge; direction bit chooses high or low side.
module hbd_core #(
    parameter int unsigned DEAD_CYC = `HBD_DEAD_CYC,
    parameter int unsigned OC_CYC   = `HBD_OC_DLY_CYC,
    parameter int unsigned OL_CYC   = `HBD_OL_DLY_CYC
) (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               inhibit_input,
    input  wire logic               vdd_uv,
    input  wire logic               vs_uv,
    input  wire logic               vs_ov,
    input  wire logic               temp_warn,
    input  wire logic               temp_shutdown,
    input  wire logic               sclk,
    input  wire logic               chip_select_low,
    input  wire logic               sdi,
    input  wire hbd_pkg::hbd_sense_s sense,
    output logic                    sdo,
    output logic                    sdo_oe,
    output logic [`HBD_NCH-1:0]     hs_on,
    output logic [`HBD_NCH-1:0]     ls_on,
    output logic                    thermal_warning_flag,
    output logic                    supply_fail_flag,
    output hbd_pkg::hbd_ctrl_s      ctrl_word
);

    localparam int W  = `HBD_WORD_W;
    localparam int SW = $bits(hbd_pkg::hbd_sense_s) + 9;
    localparam logic [SW-1:0] SYNC_RST = {{(SW - 8){1'b0}}, 1'b1, 7'h00};

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SW-1:0]       meta_q;
    logic [SW-1:0]       sync_q;
    hbd_pkg::hbd_sense_s sense_s;
    logic                sdi_s;
    logic                csn_s;
    logic                sclk_s;
    logic                tsd_s;
    logic                tw_s;
    logic                ov_s;
    logic                uv_s;
    logic                vdduv_s;
    logic                inh_s;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
        end else begin
            meta_q <= {sense, sdi, chip_select_low, sclk, temp_shutdown, temp_warn,
                       vs_ov, vs_uv, vdd_uv, inhibit_input};
            sync_q <= meta_q;
        end
    end

    assign {sense_s, sdi_s, csn_s, sclk_s, tsd_s, tw_s, ov_s, uv_s, vdduv_s, inh_s} = sync_q;

    // sleep and logic undervoltage act like a reset on everything below
    logic sys_ok;
    logic sys_rst_n;

    assign sys_ok    = inh_s & ~vdduv_s;
    assign sys_rst_n = rstn & sys_ok;

    // ------------------------------------------------------------
    // edge detection on the link
    // ------------------------------------------------------------
    logic sclk_d_q;
    logic csn_d_q;
    logic sclk_rise;
    logic sclk_fall;
    logic csn_fall;
    logic csn_rise;

    always_ff @(posedge clk) begin
        if (!sys_rst_n) begin
            sclk_d_q <= 1'b0;
            csn_d_q  <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
            csn_d_q  <= csn_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_q;
    assign sclk_fall = ~sclk_s & sclk_d_q;
    assign csn_fall  = ~csn_s & csn_d_q;
    assign csn_rise  = csn_s & ~csn_d_q;

    // ------------------------------------------------------------
    // frame sequencing
    // ------------------------------------------------------------
    hbd_pkg::hbd_frame_e state_q;

    always_ff @(posedge clk) begin
        if (!sys_rst_n) begin
            state_q <= hbd_pkg::HBD_FR_IDLE;
        end else begin
            case (state_q)
                hbd_pkg::HBD_FR_IDLE: begin
                    if (csn_fall) begin
                        state_q <= hbd_pkg::HBD_FR_SHIFT;
                    end
                end
                hbd_pkg::HBD_FR_SHIFT: begin
                    if (csn_rise) begin
                        state_q <= hbd_pkg::HBD_FR_END;
                    end
                end
                hbd_pkg::HBD_FR_END: begin
                    state_q <= csn_fall ? hbd_pkg::HBD_FR_SHIFT : hbd_pkg::HBD_FR_IDLE;
                end
                default: begin
                    state_q <= hbd_pkg::HBD_FR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // status word and shifter
    // ------------------------------------------------------------
    hbd_pkg::hbd_ctrl_s  ctrl_q;
    logic [W-1:0]        sr_q;
    logic [3:0]          cnt_q;
    logic                got_q;
    logic                sdo_q;
    logic                oe_q;
    logic                supply_fail_q;
    logic                tw_q;
    logic                tsd_q;
    logic [`HBD_NCH-1:0] oc_f;
    logic [`HBD_NCH-1:0] ol_f;
    logic [W-1:0]        status_w;
    logic                st_msb;
    logic                frame_ok;
    logic                take;
    logic                clr;
    logic                gbl_off;

    // second status address carries nothing in this block
    assign status_w = (ctrl_q.addr == `HBD_STAT_ADDR0)
                    ? {supply_fail_q, tw_q, tsd_q, oc_f, ol_f, 1'b0}
                    : '0;
    assign st_msb   = status_w[W-1];

    always_ff @(posedge clk) begin
        if (!sys_rst_n) begin
            sr_q  <= '0;
            cnt_q <= '0;
            got_q <= 1'b0;
            sdo_q <= 1'b0;
        end else if (csn_fall) begin
            sr_q  <= status_w;
            cnt_q <= '0;
            got_q <= 1'b0;
            sdo_q <= st_msb;
        end else if (state_q == hbd_pkg::HBD_FR_SHIFT && !csn_s) begin
            if (sclk_rise) begin
                sdo_q <= sr_q[W-1];
            end
            if (sclk_fall) begin
                sr_q  <= {sr_q[W-2:0], sdi_s};
                cnt_q <= cnt_q + 4'h1;
                got_q <= 1'b1;
            end
        end
    end

    // whole words only; daisy-chained frames keep the last word
    assign frame_ok = got_q && (cnt_q == 4'h0);
    assign take     = (state_q == hbd_pkg::HBD_FR_END) && frame_ok;
    assign clr      = take && sr_q[`HBD_SRR_BIT]
                   && (sr_q[`HBD_ADDR_BIT] == `HBD_STAT_ADDR0);

    always_ff @(posedge clk) begin
        if (!sys_rst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= ~csn_s;
        end
    end

    assign sdo    = sdo_q;
    assign sdo_oe = oe_q;

    // ------------------------------------------------------------
    // control word
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!sys_rst_n) begin
            ctrl_q <= `HBD_CTRL_RST;
        end else if (take) begin
            ctrl_q <= sr_q;
        end
    end

    assign ctrl_word = ctrl_q;

    // ------------------------------------------------------------
    // supply and thermal supervision
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!sys_rst_n) begin
            supply_fail_q <= 1'b0;
            tw_q          <= 1'b0;
        end else begin
            supply_fail_q <= uv_s | ov_s;
            tw_q          <= tw_s;
        end
    end

    // a sensor still hot when cleared simply sets it again
    always_ff @(posedge clk) begin
        if (!sys_rst_n) begin
            tsd_q <= 1'b0;
        end else if (tsd_s) begin
            tsd_q <= 1'b1;
        end else if (clr) begin
            tsd_q <= 1'b0;
        end
    end

    assign gbl_off              = supply_fail_q | tsd_q;
    assign supply_fail_flag     = supply_fail_q;
    assign thermal_warning_flag = tw_q;

    // ------------------------------------------------------------
    // half-bridges
    // ------------------------------------------------------------
    for (genvar g = 0; g < `HBD_NCH; g++) begin : g_ch
        hbd_chan #(
            .DEAD_CYC (DEAD_CYC),
            .OC_CYC   (OC_CYC),
            .OL_CYC   (OL_CYC)
        ) u_chan (
            .clk      (clk),
            .rst_n    (sys_rst_n),
            .en       (ctrl_q.act[g]),
            .dir      (ctrl_q.dir[g]),
            .olsd_en  (ctrl_q.olsd_en),
            .gbl_off  (gbl_off),
            .clr      (clr),
            .oc_det   (sense_s.oc[g]),
            .ol_det   (sense_s.ol[g]),
            .xcur_det (sense_s.xcur[g]),
            .hs_on    (hs_on[g]),
            .ls_on    (ls_on[g]),
            .oc_flag  (oc_f[g]),
            .ol_flag  (ol_f[g])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sdo_release_a: assert property (@(posedge clk) disable iff (!rstn)
        csn_s |=> !sdo_oe) else $error("data output driven while deselected");
    sleep_off_a: assert property (@(posedge clk) disable iff (!rstn)
        !inh_s |=> (hs_on == '0) && (ls_on == '0) && (ctrl_q == '0))
        else $error("sleep did not clear outputs and control");
    frame_take_a: assert property (@(posedge clk) disable iff (!sys_rst_n)
        take |=> (ctrl_q == $past(sr_q))) else $error("control word not taken");
    frame_drop_a: assert property (@(posedge clk) disable iff (!sys_rst_n)
        !take |=> $stable(ctrl_q)) else $error("control word changed without frame");
    capture_a: assert property (@(posedge clk) disable iff (!sys_rst_n)
        csn_fall |=> (sdo == $past(st_msb))) else $error("status not captured");
    supply_off_a: assert property (@(posedge clk) disable iff (!sys_rst_n)
        supply_fail_flag |=> (hs_on == '0) && (ls_on == '0))
        else $error("outputs on during supply fail");
    tsd_hold_a: assert property (@(posedge clk) disable iff (!sys_rst_n)
        (tsd_q && !clr) |=> tsd_q && (hs_on == '0) && (ls_on == '0))
        else $error("thermal shutdown released early");
    tw_follow_a: assert property (@(posedge clk) disable iff (!sys_rst_n)
        tw_s |=> thermal_warning_flag) else $error("thermal warning not shown");

endmodule : hbd_core
`default_nettype wire

// file: hbd_params.svh
// constants of the half-bridge driver control and diagnosis block
`ifndef HBD_PARAMS_SVH
`define HBD_PARAMS_SVH

`define HBD_WORD_W      16
`define HBD_NCH         6
`define HBD_SRR_BIT     15
`define HBD_ADDR_BIT    14
`define HBD_STAT_ADDR0  1'b0
`define HBD_CTRL_RST    16'h0000

`define HBD_CLK_NS      8
`define HBD_DEAD_NS     500
`define HBD_OC_DLY_NS   10000
`define HBD_OL_DLY_NS   30000
`define HBD_DEAD_CYC    ((`HBD_DEAD_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS)
`define HBD_OC_DLY_CYC  ((`HBD_OC_DLY_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS)
`define HBD_OL_DLY_CYC  ((`HBD_OL_DLY_NS + `HBD_CLK_NS - 1) / `HBD_CLK_NS)

`endif

// file: hbd_pkg.sv
// types of the half-bridge driver control and diagnosis block
`default_nettype none
`include "hbd_params.svh"

package hbd_pkg;

    // control word, bit 15 down to bit 0
    typedef struct packed {
        logic                    status_clear_request;
        logic                    addr;
        logic                    olsd_en;
        logic [`HBD_NCH-1:0]     act;
        logic [`HBD_NCH-1:0]     dir;
        logic                    rsv;
    } hbd_ctrl_s;

    // analog comparator outputs, one bit per half-bridge
    typedef struct packed {
        logic [`HBD_NCH-1:0]     oc;
        logic [`HBD_NCH-1:0]     ol;
        logic [`HBD_NCH-1:0]     xcur;
    } hbd_sense_s;

    typedef enum logic [1:0] {
        HBD_FR_IDLE  = 2'b00,
        HBD_FR_SHIFT = 2'b01,
        HBD_FR_END   = 2'b11
    } hbd_frame_e;

endpackage : hbd_pkg
`default_nettype wire

// file: hbd_chan.sv
// one half-bridge: dead-time switching, fault qualification and latches
`timescale 1ns/1ps
`default_nettype none
`include "hbd_params.svh"

module hbd_chan #(
    parameter int unsigned DEAD_CYC = `HBD_DEAD_CYC,
    parameter int unsigned OC_CYC   = `HBD_OC_DLY_CYC,
    parameter int unsigned OL_CYC   = `HBD_OL_DLY_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    input  wire logic dir,
    input  wire logic olsd_en,
    input  wire logic gbl_off,
    input  wire logic clr,
    input  wire logic oc_det,
    input  wire logic ol_det,
    input  wire logic xcur_det,
    output logic      hs_on,
    output logic      ls_on,
    output logic      oc_flag,
    output logic      ol_flag
);

    localparam int CW = 16;
    localparam logic [CW-1:0] DEAD_LIM = CW'(DEAD_CYC);
    localparam logic [CW-1:0] OC_LIM   = CW'(OC_CYC - 1);
    localparam logic [CW-1:0] OL_LIM   = CW'(OL_CYC - 1);

    logic [CW-1:0] dt_q;
    logic [CW-1:0] oc_cnt_q;
    logic [CW-1:0] ol_cnt_q;
    logic          oc_l_q;
    logic          ol_l_q;
    logic          ol_off_q;
    logic          fault;
    logic          want_hs;
    logic          want_ls;
    logic          oc_cond;
    logic          ol_cond;
    logic          oc_hit;
    logic          ol_hit;

    assign fault   = oc_l_q | ol_off_q | xcur_det | gbl_off;
    assign want_hs = en & dir & ~fault;
    assign want_ls = en & ~dir & ~fault;
    assign oc_cond = (hs_on | ls_on) & oc_det;
    assign ol_cond = ls_on & ol_det;
    assign oc_hit  = oc_cond && (oc_cnt_q == OC_LIM);
    assign ol_hit  = ol_cond && (ol_cnt_q == OL_LIM);
    assign oc_flag = oc_l_q;
    assign ol_flag = ol_l_q;

    // ------------------------------------------------------------
    // delay qualification
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oc_cnt_q <= '0;
            ol_cnt_q <= '0;
        end else begin
            if (!oc_cond) begin
                oc_cnt_q <= '0;
            end else if (!oc_hit) begin
                oc_cnt_q <= oc_cnt_q + CW'(1);
            end
            if (!ol_cond) begin
                ol_cnt_q <= '0;
            end else if (!ol_hit) begin
                ol_cnt_q <= ol_cnt_q + CW'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // fault latches, a new detection beats the clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oc_l_q   <= 1'b0;
            ol_l_q   <= 1'b0;
            ol_off_q <= 1'b0;
        end else begin
            if (oc_hit || xcur_det) begin
                oc_l_q <= 1'b1;
            end else if (clr) begin
                oc_l_q <= 1'b0;
            end
            if (ol_hit) begin
                ol_l_q <= 1'b1;
            end else if (clr) begin
                ol_l_q <= 1'b0;
            end
            if (ol_hit && olsd_en) begin
                ol_off_q <= 1'b1;
            end else if (clr) begin
                ol_off_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // switch sequencing: off first, dead time, then on
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hs_on <= 1'b0;
            ls_on <= 1'b0;
            dt_q  <= '0;
        end else if ((hs_on && !want_hs) || (ls_on && !want_ls)) begin
            hs_on <= hs_on & want_hs;
            ls_on <= ls_on & want_ls;
            dt_q  <= DEAD_LIM;
        end else if (dt_q != '0) begin
            dt_q <= dt_q - CW'(1);
        end else if (want_hs && !ls_on) begin
            hs_on <= 1'b1;
        end else if (want_ls && !hs_on) begin
            ls_on <= 1'b1;
        end
    end

    sequence oc_expiry_s;
        oc_hit;
    endsequence

    sequence stage_off_s;
        !hs_on && !ls_on;
    endsequence

    no_overlap_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(hs_on && ls_on)) else $error("both switches of a bridge are on");
    dead_time_a: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(hs_on) || $rose(ls_on)) |-> ($past(dt_q) == '0))
        else $error("switch turned on inside dead time");
    xcur_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        xcur_det |=> oc_flag ##0 stage_off_s) else $error("cross-current not handled");
    oc_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
        oc_expiry_s |=> oc_flag ##1 stage_off_s) else $error("overcurrent not tripped");
    ol_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        ol_hit |=> ol_flag) else $error("open load not latched");
    ol_shut_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ol_hit && olsd_en) |=> ##1 !ls_on) else $error("open load did not shut stage");

endmodule : hbd_chan
`default_nettype wire

// file: hbd_spi_master.sv
// serial master model that drives frames into the half-bridge block
`timescale 1ns/1ps
`default_nettype none
module hbd_spi_master (
    input  wire logic clk,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    output logic      sclk,
    output logic      chip_select_low,
    output logic      sdi
);
    initial begin
        sclk = 1'b0;
        chip_select_low = 1'b1;
        sdi = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // sdo taken just before each fall; x when the line is released
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        chip_select_low = 1'b0;
        wt(5);
        for (int i = n - 1; i >= 0; i--) begin
            sdi = tx[i];
            wt(4);
            sclk = 1'b1;
            wt(5);
            // device moves sdo on the rise, so the bit is valid at the fall
            rx = {rx[30:0], sdo_oe ? sdo : 1'bx};
            sclk = 1'b0;
            // sdi held one clock past the fall: 80 ns per bit
            wt(1);
        end
        // hold time over, so the line stops showing the last bit
        sdi = ~sdi;
        wt(2);
        chip_select_low = 1'b1;
        wt(12);
    endtask : xfer
endmodule : hbd_spi_master
`default_nettype wire

// file: hbd_core_tb.sv
// self-checking bench of the half-bridge control block
`timescale 1ns/1ps
`default_nettype none
module hbd_core_tb;
    localparam int unsigned OCC = 8;
    logic        clk, rstn, inhibit_input, vdd_uv, vs_uv, vs_ov, temp_warn, temp_shutdown;
    logic        sclk, chip_select_low, sdi, sdo, sdo_oe, thermal_warning_flag;
    logic        supply_fail_flag;
    logic [5:0]  hs_on, ls_on;
    logic [31:0] rx;
    int          fails = 0;
    int          comparisons = 0;
    hbd_pkg::hbd_sense_s sense;
    hbd_pkg::hbd_ctrl_s  ctrl_word;
    hbd_core #(.DEAD_CYC(4), .OC_CYC(OCC), .OL_CYC(OCC)) u_hbd_core (
        .clk(clk), .rstn(rstn), .inhibit_input(inhibit_input), .vdd_uv(vdd_uv),
        .vs_uv(vs_uv), .vs_ov(vs_ov), .temp_warn(temp_warn), .temp_shutdown(temp_shutdown),
        .sclk(sclk), .chip_select_low(chip_select_low), .sdi(sdi), .sense(sense),
        .sdo(sdo), .sdo_oe(sdo_oe), .hs_on(hs_on), .ls_on(ls_on),
        .thermal_warning_flag(thermal_warning_flag), .supply_fail_flag(supply_fail_flag),
        .ctrl_word(ctrl_word));
    hbd_spi_master u_hbd_spi_master (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk),
        .chip_select_low(chip_select_low), .sdi(sdi));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic fr(input logic [31:0] tx, input int n = 16);
        u_hbd_spi_master.xfer(tx, n, rx);
    endtask : fr
    // c = {status clear, address, open load shutdown}
    function automatic logic [15:0] cw(input logic [2:0] c, logic [5:0] a, d);
        return {c, a, d, 1'b0};
    endfunction : cw
    // f = {supply fail, warning, shutdown latch}
    function automatic logic [15:0] st(input logic [2:0] f, logic [5:0] oc, ol);
        return {f, oc, ol, 1'b0};
    endfunction : st
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    initial begin
        {rstn, vdd_uv, vs_uv, vs_ov, temp_warn, temp_shutdown} = 6'h00;
        inhibit_input = 1'b1;
        sense = 18'h0;
        wt(20);
        chk({hs_on, ls_on, sdo_oe, ctrl_word}, 32'h0);
        rstn = 1'b1;
        wt(6);
        fr(cw(3'h0, 6'h01, 6'h01));
        chk(ctrl_word, cw(3'h0, 6'h01, 6'h01));
        chk(sdo_oe, 32'h0);
        wt(4);
        chk({hs_on, ls_on}, 32'h040);
        fr(cw(3'h0, 6'h01, 6'h00));
        chk(rx, 32'h0);
        wt(4);
        chk({hs_on, ls_on}, 32'h001);
        // without shutdown enable an open load only flags
        sense.ol = 6'h01;
        wt(OCC + 4);
        sense.ol = 6'h00;
        chk(ls_on, 32'h01);
        fr(cw(3'h0, 6'h3f, 6'h3f), 8);
        chk(ctrl_word, cw(3'h0, 6'h01, 6'h00));
        // two words in one frame: only the last one is taken
        fr({16'ha5c3, cw(3'h1, 6'h03, 6'h02)}, 32);
        chk(rx, {st(3'h0, 6'h00, 6'h01), 16'ha5c3});
        wt(4);
        chk({hs_on, ls_on}, 32'h081);
        sense.ol = 6'h01;
        wt(OCC + 4);
        sense.ol = 6'h00;
        chk(ls_on, 32'h0);
        // two short bursts must not add up
        for (int k = 0; k < 2; k++) begin
            sense.oc = 6'h02;
            wt(OCC - 3);
            sense.oc = 6'h00;
            wt(2);
        end
        wt(2);
        chk(hs_on, 32'h02);
        sense.oc = 6'h02;
        wt(OCC + 4);
        sense.oc = 6'h00;
        chk(hs_on, 32'h0);
        fr(cw(3'h5, 6'h03, 6'h02));
        chk(rx, st(3'h0, 6'h02, 6'h01));
        wt(4);
        chk({hs_on, ls_on}, 32'h081);
        sense.xcur = 6'h01;
        wt(4);
        sense.xcur = 6'h00;
        chk(ls_on, 32'h0);
        fr(cw(3'h5, 6'h03, 6'h02));
        chk(rx, st(3'h0, 6'h01, 6'h00));
        wt(4);
        for (int k = 0; k < 2; k++) begin
            {vs_ov, vs_uv} = (k == 0) ? 2'b01 : 2'b10;
            wt(5);
            chk({supply_fail_flag, hs_on, ls_on}, 32'h1000);
            fr(cw(3'h1, 6'h03, 6'h02));
            chk(rx, st(3'h4, 6'h00, 6'h00));
            {vs_ov, vs_uv} = 2'b00;
            wt(10);
            chk({supply_fail_flag, hs_on, ls_on}, 32'h0081);
        end
        temp_warn = 1'b1;
        wt(5);
        chk(thermal_warning_flag, 32'h1);
        fr(cw(3'h3, 6'h03, 6'h02));
        chk(rx, st(3'h2, 6'h00, 6'h00));
        fr(cw(3'h1, 6'h03, 6'h02));
        chk(rx, 32'h0);
        temp_warn = 1'b0;
        wt(5);
        chk(thermal_warning_flag, 32'h0);
        temp_shutdown = 1'b1;
        wt(5);
        temp_shutdown = 1'b0;
        wt(5);
        chk({hs_on, ls_on}, 32'h0);
        fr(cw(3'h5, 6'h03, 6'h02));
        chk(rx, st(3'h1, 6'h00, 6'h00));
        wt(4);
        chk({hs_on, ls_on}, 32'h081);
        for (int k = 0; k < 2; k++) begin
            {inhibit_input, vdd_uv} = (k == 0) ? 2'b00 : 2'b11;
            wt(6);
            chk({hs_on, ls_on, ctrl_word}, 32'h0);
            {inhibit_input, vdd_uv} = 2'b10;
            wt(6);
            fr(cw(3'h1, 6'h03, 6'h02));
            chk(ctrl_word, cw(3'h1, 6'h03, 6'h02));
        end
        conclude();
    end
    // tests need about 2600 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule : hbd_core_tb
`default_nettype wire
